// ---- design/lifecycle_transit_command.sv ----
// Lifecycle transit command interpreter
// What this block does
// - Request: 01h, length 0003h, 71h, src, dst, sum, 03h
// - Success reply: 81h, 000Ah, 71h, 00h, filler, 8Dh, 03h
// - Failure reply: 81h, 000Ah, F1h, status, filler, sum, 03h
// - Transition needs no authentication
// - After locked or returned, halt until reset
// - Command not allowed in state gets acceptance error
// - Locked-boot device resets itself during initialisation
// - Acceptance error status is D5h
// - Missing end byte gives packet error, no change
// - Source mismatch gives parameter error, no change
// - Disabled locked-boot destination gives protection error
`timescale 1ns/1ps
`default_nettype none
`include "lifecycle_transit_cfg.svh"
module lifecycle_transit_command
  import lifecycle_transit_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       clk_en_i,
  input  wire logic [7:0] stored_state_i,
  input  wire logic       lock_transit_enable_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       rx_valid_i,
  output logic [7:0]      tx_data_o,
  output logic            tx_valid_o,
  input  wire logic       tx_ready_i,
  output logic [7:0]      lifecycle_state_o,
  output logic            state_write_o,
  output logic            soft_reset_o,
  output logic            halted_o
);
  transit_state_e state;
  logic [7:0]     lifecycle_state;
  logic [7:0]     frame [0:7];
  logic [2:0]     count;
  logic [7:0]     sum;
  logic [7:0]     status;
  logic           do_halt;
  logic           end_ok;
  logic           sum_ok;
  logic           length_ok;
  logic           code_ok;
  logic           accepted;
  logic           source_ok;
  logic           pair_ok;
  logic           lock_blocked;
  logic           locked_at_boot;
  logic           commit;
  reply_if        rif();

  ////////////////////////////////////////////////////////////////////////
  // Permitted states for this command
  function automatic logic transit_allowed(input logic [7:0] s);
    transit_allowed = (s == `STATE_MANUFACTURER) || (s == `STATE_RETURN_ACK);
  endfunction

  // Legal pair of source and destination without authentication
  function automatic logic pair_legal(input logic [7:0] src, input logic [7:0] dst);
    pair_legal = (src == `STATE_MANUFACTURER && dst == `STATE_LOCKED_BOOT) ||
                 (src == `STATE_RETURN_ACK && dst == `STATE_RETURNED);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Request checks, one flag each
  assign end_ok         = (frame[`REQ_LAST_INDEX] == `END_OF_FRAME_BYTE);
  assign sum_ok         = (sum == 8'h00);
  assign length_ok      = (frame[`IDX_LEN_HIGH] == `CMD_LEN_HIGH) &&
                          (frame[`IDX_LEN_LOW] == `CMD_LEN_LOW);
  assign code_ok        = (frame[`IDX_CODE] == `TRANSIT_CMD_CODE);
  assign accepted       = transit_allowed(lifecycle_state);
  assign source_ok      = (frame[`IDX_SOURCE] == lifecycle_state);
  assign pair_ok        = pair_legal(frame[`IDX_SOURCE], frame[`IDX_DEST]);
  assign lock_blocked   = (frame[`IDX_DEST] == `STATE_LOCKED_BOOT) && !lock_transit_enable_i;
  assign locked_at_boot = (stored_state_i == `STATE_LOCKED_BOOT);

  // Status in descending priority
  always_comb begin
    if (!end_ok)
      status = `STATUS_PACKET_ERR;
    else if (!sum_ok)
      status = `STATUS_CHECKSUM_ERR;
    else if (!length_ok || !code_ok)
      status = `STATUS_PACKET_ERR;
    else if (!accepted)
      status = `STATUS_ACCEPT_ERR;
    else if (!source_ok)
      status = `STATUS_PARAM_ERR;
    else if (!pair_ok)
      status = `STATUS_PARAM_ERR;
    else if (lock_blocked)
      status = `STATUS_PROTECT_ERR;
    else
      status = `STATUS_OK;
  end

  // Transit taken only in the check cycle with a clean status
  assign commit = (state == st_check) && (status == `STATUS_OK);

  assign rif.start  = (state == st_check);
  assign rif.is_ok  = (status == `STATUS_OK);
  assign rif.status = status;

  ////////////////////////////////////////////////////////////////////////
  // Receive sequencing
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= st_boot;
      count <= 3'd0;
    end else if (clk_en_i) begin
      case (state)
        st_boot: begin
          if (locked_at_boot)
            state <= st_boot;
          else
            state <= st_wait_start;
        end
        st_wait_start: begin
          if (rx_valid_i && rx_data_i == `CMD_START_BYTE) begin
            state <= st_receive;
            count <= 3'd1;
          end
        end
        st_receive: begin
          if (rx_valid_i) begin
            if (count == `REQ_LAST_INDEX)
              state <= st_check;
            else
              count <= count + 3'd1;
          end
        end
        st_check: state <= st_reply;
        st_reply: begin
          if (!rif.busy)
            state <= do_halt ? st_halted : st_wait_start;
        end
        st_halted: state <= st_halted;
        default:   state <= st_wait_start;
      endcase
    end
  end

  // Frame capture
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++)
        frame[i] <= 8'h00;
    end else if (clk_en_i) begin
      if (state == st_wait_start && rx_valid_i)
        frame[0] <= rx_data_i;
      else if (state == st_receive && rx_valid_i)
        frame[count] <= rx_data_i;
    end
  end

  // Running sum from length high byte through checksum
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sum <= 8'h00;
    end else if (clk_en_i) begin
      if (state == st_wait_start && rx_valid_i)
        sum <= 8'h00;
      else if (state == st_receive && rx_valid_i && count <= `IDX_SUM)
        sum <= sum + rx_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lifecycle state: loaded at boot, replaced on a committed transit
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lifecycle_state <= 8'h00;
    end else if (clk_en_i) begin
      if (state == st_boot)
        lifecycle_state <= stored_state_i;
      else if (commit)
        lifecycle_state <= frame[`IDX_DEST];
    end
  end

  // Storage write strobe, one cycle per committed transit
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_write_o <= 1'b0;
    end else if (clk_en_i) begin
      state_write_o <= commit;
    end
  end

  // Both targets are final: any committed transit ends handling
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      do_halt <= 1'b0;
    end else if (clk_en_i) begin
      if (commit)
        do_halt <= 1'b1;
    end
  end

  // Locked part never leaves boot and keeps asking for a reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      soft_reset_o <= 1'b0;
    end else if (clk_en_i) begin
      soft_reset_o <= (state == st_boot) && locked_at_boot;
    end
  end

  assign lifecycle_state_o = lifecycle_state;
  assign halted_o          = (state == st_halted);

  reply_framer u_framer (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .clk_en_i   (clk_en_i),
    .req        (rif.framer),
    .tx_data_o  (tx_data_o),
    .tx_valid_o (tx_valid_o),
    .tx_ready_i (tx_ready_i)
  );
endmodule
`default_nettype wire

// ---- shared/lifecycle_transit_cfg.svh ----
// Constants for the lifecycle transit command block
`ifndef LIFECYCLE_TRANSIT_CFG_SVH
`define LIFECYCLE_TRANSIT_CFG_SVH

`define CMD_START_BYTE      8'h01
`define REPLY_START_BYTE    8'h81
`define END_OF_FRAME_BYTE   8'h03
`define CMD_LEN_HIGH        8'h00
`define CMD_LEN_LOW         8'h03
`define REPLY_LEN_HIGH      8'h00
`define REPLY_LEN_LOW       8'h0a
`define TRANSIT_CMD_CODE    8'h71
`define TRANSIT_ERR_CODE    8'hf1
`define OK_CHECKSUM         8'h8d
`define FILLER_BYTE         8'hff
`define STATUS_OK           8'h00
`define STATUS_PACKET_ERR   8'hc1
`define STATUS_CHECKSUM_ERR 8'hc2
`define STATUS_PARAM_ERR    8'hd0
`define STATUS_ACCEPT_ERR   8'hd5
`define STATUS_PROTECT_ERR  8'hda
`define STATE_MANUFACTURER  8'h04
`define STATE_LOCKED_BOOT   8'h06
`define STATE_RETURN_REQ    8'h07
`define STATE_RETURN_ACK    8'h08
`define STATE_RETURNED      8'h09
`define REPLY_BYTES         4'd15
`define REQ_LAST_INDEX      3'd7
`define IDX_LEN_HIGH        3'd1
`define IDX_LEN_LOW         3'd2
`define IDX_CODE            3'd3
`define IDX_SOURCE          3'd4
`define IDX_DEST            3'd5
`define IDX_SUM             3'd6
`define IDX_STATUS          4'd4
`define IDX_FILL_FIRST      4'd5
`define IDX_FILL_LAST       4'd12
`define IDX_REPLY_SUM       4'd13
`define IDX_REPLY_END       4'd14
`define IDX_RESP            4'd3
`define IDX_REPLY_START     4'd0
`define IDX_REPLY_LEN_HIGH  4'd1
`define IDX_REPLY_LEN_LOW   4'd2

`endif

// ---- shared/lifecycle_transit_pkg.sv ----
// Types for the lifecycle transit command block
package lifecycle_transit_pkg;
  typedef enum logic [2:0] {
    st_boot,
    st_wait_start,
    st_receive,
    st_check,
    st_reply,
    st_halted
  } transit_state_e;
endpackage

// ---- shared/reply_if.sv ----
// Reply request carried from the interpreter to the reply framer
`timescale 1ns/1ps
`default_nettype none
interface reply_if;
  logic       start;
  logic       is_ok;
  logic [7:0] status;
  logic       busy;
  modport requester (output start, output is_ok, output status, input busy);
  modport framer    (input start, input is_ok, input status, output busy);
endinterface
`default_nettype wire

// ---- design/reply_framer.sv ----
// Serialises the fifteen byte reply packet
`timescale 1ns/1ps
`default_nettype none
`include "lifecycle_transit_cfg.svh"
module reply_framer
  import lifecycle_transit_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       clk_en_i,
  reply_if.framer         req,
  output logic [7:0]      tx_data_o,
  output logic            tx_valid_o,
  input  wire logic       tx_ready_i
);
  logic [3:0] index;
  logic       active;
  logic       is_ok;
  logic [7:0] status;
  logic [7:0] sum;
  logic [7:0] next_byte;

  assign req.busy   = active;
  assign tx_valid_o = active;

  always_comb begin
    case (index)
      `IDX_REPLY_START:    next_byte = `REPLY_START_BYTE;
      `IDX_REPLY_LEN_HIGH: next_byte = `REPLY_LEN_HIGH;
      `IDX_REPLY_LEN_LOW:  next_byte = `REPLY_LEN_LOW;
      `IDX_RESP:           next_byte = is_ok ? `TRANSIT_CMD_CODE : `TRANSIT_ERR_CODE;
      `IDX_STATUS:         next_byte = status;
      `IDX_REPLY_SUM:      next_byte = is_ok ? `OK_CHECKSUM : 8'(~sum + 8'h01);
      `IDX_REPLY_END:      next_byte = `END_OF_FRAME_BYTE;
      default:             next_byte = `FILLER_BYTE;
    endcase
  end

  // Shift pointer is one ahead: tx_data_o holds the byte before index, next_byte is the byte for index
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      active    <= 1'b0;
      index     <= 4'h0;
      tx_data_o <= 8'h00;
      is_ok     <= 1'b0;
      status    <= 8'h00;
      sum       <= 8'h00;
    end else if (clk_en_i) begin
      if (!active && req.start) begin
        active    <= 1'b1;
        is_ok     <= req.is_ok;
        status    <= req.status;
        index     <= 4'h1;
        tx_data_o <= `REPLY_START_BYTE;
        sum       <= 8'h00;
      end else if (active && tx_ready_i) begin
        if (index == `REPLY_BYTES) begin
          active <= 1'b0;
        end else begin
          index     <= index + 4'h1;
          tx_data_o <= next_byte;
          if (index >= `IDX_REPLY_LEN_HIGH && index <= `IDX_FILL_LAST)
            sum <= sum + next_byte;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/lifecycle_transit_command_assertions.sv ----
// Checker for the lifecycle transit command block
`timescale 1ns/1ps
`default_nettype none
module lifecycle_transit_command_assertions (
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_valid_o,
  input wire logic       tx_ready_i,
  input wire logic [7:0] lifecycle_state_o,
  input wire logic       state_write_o,
  input wire logic       soft_reset_o,
  input wire logic       halted_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence held_byte;
    tx_valid_o && !tx_ready_i;
  endsequence
  sequence same_byte;
    tx_valid_o && $stable(tx_data_o);
  endsequence
  first_byte_a: assert property ($rose(tx_valid_o) |-> tx_data_o == 8'h81)
    else $error("bad first byte");
  byte_hold_a: assert property (held_byte |=> same_byte)
    else $error("byte not held");
  halt_sticky_a: assert property (halted_o |=> halted_o)
    else $error("halt dropped");
  halt_quiet_a: assert property (halted_o |-> !tx_valid_o && !state_write_o)
    else $error("active while halted");
  locked_quiet_a: assert property (soft_reset_o |-> !tx_valid_o && !state_write_o && !halted_o)
    else $error("active while locked");
  write_target_a: assert property (state_write_o |-> lifecycle_state_o inside {8'h06, 8'h09})
    else $error("bad target state");
  write_reply_a: assert property (state_write_o |-> tx_valid_o && tx_data_o == 8'h81)
    else $error("write without reply");
  write_pulse_a: assert property (state_write_o |=> !state_write_o)
    else $error("write not a pulse");
  halt_cause_a: assert property ($rose(halted_o) |-> lifecycle_state_o inside {8'h06, 8'h09})
    else $error("halt without transit");
endmodule
bind lifecycle_transit_command lifecycle_transit_command_assertions chk (
  .core_clk_i        (core_clk_i),
  .rst_i             (rst_i),
  .tx_data_o         (tx_data_o),
  .tx_valid_o        (tx_valid_o),
  .tx_ready_i        (tx_ready_i),
  .lifecycle_state_o (lifecycle_state_o),
  .state_write_o     (state_write_o),
  .soft_reset_o      (soft_reset_o),
  .halted_o          (halted_o)
);
`default_nettype wire

// ---- verification/host_tool_model.sv ----
// Host tool model: sends transit frames, collects reply bytes
`timescale 1ns/1ps
`default_nettype none
module host_tool_model (
  input  wire logic       core_clk_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic [7:0]      rx_data_o,
  output logic            rx_valid_o,
  output logic            tx_ready_o
);
  logic       tick = 1'b0;
  logic [7:0] got[$];
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
  end
  always @(negedge core_clk_i) tick <= ~tick;
  assign tx_ready_o = !slow_i || tick;
  always @(posedge core_clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_data_i);
    end
  end
  task automatic send(input logic [7:0] s, input logic [7:0] d, input logic bs, input logic be);
    logic [7:0] f[8];
    f = '{8'h01, 8'h00, 8'h03, 8'h71, s, d, 8'h00, 8'h03};
    f[6] = 8'h00 - (8'h03 + 8'h71 + s + d) + {7'h00, bs};
    f[7] = be ? 8'h04 : 8'h03;
    for (int i = 0; i < 8; i++) begin
      @(negedge core_clk_i);
      rx_data_o = f[i];
      rx_valid_o = 1'b1;
      @(negedge core_clk_i);
      rx_valid_o = 1'b0;
      rx_data_o = ~f[i];
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/lifecycle_transit_command_tb.sv ----
// Self-checking testbench for the lifecycle transit command block
`timescale 1ns/1ps
`default_nettype none
module lifecycle_transit_command_tb;
  logic       core_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [7:0] stored_state_i = 8'h04;
  logic       lock_transit_enable_i = 1'b0;
  logic       slow = 1'b0;
  logic [7:0] rx_data_i, tx_data_o, lifecycle_state_o;
  logic       rx_valid_i, tx_valid_o, tx_ready_i, state_write_o, soft_reset_o, halted_o;
  int         errors = 0;
  int         comparisons = 0;
  int         writes = 0;
  always #5 core_clk_i = ~core_clk_i;
  // Counts storage write strobes
  always @(posedge core_clk_i) begin
    if (state_write_o) begin
      writes++;
    end
  end
  lifecycle_transit_command uut (
    .core_clk_i            (core_clk_i),
    .rst_i                 (rst_i),
    .clk_en_i              (1'b1),
    .stored_state_i        (stored_state_i),
    .lock_transit_enable_i (lock_transit_enable_i),
    .rx_data_i             (rx_data_i),
    .rx_valid_i            (rx_valid_i),
    .tx_data_o             (tx_data_o),
    .tx_valid_o            (tx_valid_o),
    .tx_ready_i            (tx_ready_i),
    .lifecycle_state_o     (lifecycle_state_o),
    .state_write_o         (state_write_o),
    .soft_reset_o          (soft_reset_o),
    .halted_o              (halted_o)
  );
  host_tool_model host (.core_clk_i(core_clk_i), .slow_i(slow), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
    .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i), .tx_ready_o(tx_ready_i));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic boot(input logic [7:0] s, input logic e);
    @(negedge core_clk_i);
    rst_i = 1'b1;
    writes = 0;
    stored_state_i = s;
    lock_transit_enable_i = e;
    repeat (2) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
  endtask
  task automatic run(input logic [7:0] s, input logic [7:0] d, input logic bs, input logic be, input logic [7:0] st);
    logic [7:0] e[15];
    logic [7:0] sum;
    int n;
    host.got.delete();
    host.send(s, d, bs, be);
    sum = 8'h00;
    for (int i = 0; i < 15; i++) begin
      e[i] = (i > 4) ? 8'hff : 8'h00;
    end
    e[0] = 8'h81;
    e[2] = 8'h0a;
    e[3] = (st == 8'h00) ? 8'h71 : 8'hf1;
    e[4] = st;
    for (int i = 1; i < 13; i++) begin
      sum = sum + e[i];
    end
    e[13] = 8'h00 - sum;
    e[14] = 8'h03;
    n = 0;
    while (host.got.size() < 15 && n < 400) begin
      @(negedge core_clk_i);
      n++;
    end
    if (host.got.size() < 15) begin
      chk(8'(host.got.size()), 8'h0f);
      final_report();
    end
    repeat (20) @(negedge core_clk_i);
    chk(8'(host.got.size()), 8'h0f);
    for (int i = 0; i < 15; i++) begin
      chk(host.got[i], e[i]);
    end
  endtask
  task automatic quiet(input logic [7:0] s, input logic [7:0] d);
    host.got.delete();
    host.send(s, d, 1'b0, 1'b0);
    repeat (40) @(negedge core_clk_i);
    chk(8'(host.got.size()), 8'h00);
  endtask
  task automatic oem_errors();
    boot(8'h04, 1'b0);
    run(8'h04, 8'h06, 1'b0, 1'b1, 8'hc1);
    run(8'h04, 8'h06, 1'b1, 1'b0, 8'hc2);
    run(8'h08, 8'h09, 1'b0, 1'b0, 8'hd0);
    run(8'h04, 8'h09, 1'b0, 1'b0, 8'hd0);
    run(8'h04, 8'h06, 1'b0, 1'b0, 8'hda);
    chk(lifecycle_state_o, 8'h04);
    chk(8'(writes), 8'h00);
    chk({7'h00, halted_o}, 8'h00);
  endtask
  task automatic oem_lock();
    boot(8'h04, 1'b1);
    slow = 1'b1;
    run(8'h04, 8'h06, 1'b0, 1'b0, 8'h00);
    chk(lifecycle_state_o, 8'h06);
    chk({7'h00, halted_o}, 8'h01);
    chk(8'(writes), 8'h01);
    quiet(8'h04, 8'h06);
    chk(8'(writes), 8'h01);
    slow = 1'b0;
  endtask
  task automatic rma_return();
    boot(8'h08, 1'b0);
    run(8'h08, 8'h09, 1'b0, 1'b0, 8'h00);
    chk(lifecycle_state_o, 8'h09);
    chk(8'(writes), 8'h01);
  endtask
  task automatic not_accepted();
    boot(8'h07, 1'b1);
    run(8'h04, 8'h06, 1'b0, 1'b0, 8'hd5);
    chk(lifecycle_state_o, 8'h07);
    chk(8'(writes), 8'h00);
  endtask
  task automatic locked_boot();
    boot(8'h06, 1'b1);
    chk({7'h00, soft_reset_o}, 8'h01);
    quiet(8'h04, 8'h06);
    chk(8'(writes), 8'h00);
  endtask
  initial begin
    oem_errors();
    oem_lock();
    rma_return();
    not_accepted();
    locked_boot();
    final_report();
  end
endmodule
`default_nettype wire
